//--- dqa_top.v
`timescale 1ns/10ps
`default_nettype none
`include "dqa_map.vh"

// How it works
// - a core burst spans only 8 bytes: C and D pair per master
// - split window mixing masters is answered with an error
// - buffer-held protocol words set bit 22 of descriptor word 0
// - bit 22 at zero means protocol words sit in the descriptor
// - a peer descriptor's bit 22 tells where its protocol words are
// - each software flow entry holds the protocol word location
// - when enabled, the transmit tag is copied into the receive word
module dqa_top #(
  parameter QDEPTH = 16,
  parameter QAW = 4,
  parameter FLOWS = 4,
  parameter FW = 2
) (
  input wire clk_i,              // system clock
  input wire rst_i,              // synchronous reset
  input wire cyc_i,              // wishbone cycle
  input wire stb_i,              // wishbone strobe
  input wire we_i,               // wishbone write
  input wire [7:0] adr_i,        // wishbone byte address
  input wire [3:0] sel_i,        // wishbone byte enables
  input wire [31:0] dat_i,       // wishbone write data
  output wire [31:0] dat_o,      // wishbone read data
  output wire ack_o,             // wishbone ack
  output wire err_o,             // wishbone error
  input wire [3:0] mst_id_i,     // id of requesting master
  input wire rx_valid_i,         // received packet offered
  output wire rx_ready_o,        // packet taken
  input wire [FW-1:0] rx_flow_i, // receive flow number
  input wire [21:0] rx_len_i,    // packet length
  input wire [7:0] rx_tag_i,     // tag from transmit descriptor
  output wire dsc_valid_o,       // descriptor word 0 ready
  input wire dsc_ready_i,        // memory writer takes it
  output wire [31:0] dsc_word0_o, // descriptor word 0
  input wire peer_valid_i,       // descriptor from a peer module
  input wire [31:0] peer_word0_i, // peer descriptor word 0
  output wire peer_info_buf_o,   // peer protocol words in buffer
  output wire swap_cd_o          // little-endian swap in force
);

  // byte-enable merge, used by the bulk and split C words
  function [31:0] dqa_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer i;
    begin
      dqa_merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (sel[i])
          dqa_merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  reg [31:0] qptr_ff [0:QDEPTH-1];
  reg [31:0] qsize_ff [0:QDEPTH-1];
  reg [QAW-1:0] wr_ff;
  reg [QAW-1:0] rd_ff;
  reg [QAW:0] cnt_ff;
  reg [31:0] bytes_ff;
  reg [31:0] bulk_c_ff;
  reg bulk_c_vld_ff;
  reg [3:0] bulk_own_ff;
  reg [31:0] prxy_c_ff;
  reg prxy_busy_ff;
  reg [3:0] prxy_own_ff;
  reg [31:0] ctrl_ff;
  reg [1:0] flow_ff [0:FLOWS-1];
  reg prxy_err_ff;
  reg ovfl_ff;
  reg ack_ff;
  reg err_ff;
  reg [31:0] dat_ff;
  reg peer_info_ff;

  reg hit_bulk_c;
  reg hit_bulk_d;
  reg hit_peri_d;
  reg hit_prxy_c;
  reg hit_prxy_d;
  reg hit_cnt;
  reg hit_size;
  reg hit_bytes;
  reg hit_ctrl;
  reg hit_stat;
  reg hit_flow;
  reg [FW-1:0] flow_idx;

  wire req;
  wire wr;
  wire rd;
  wire q_full;
  wire q_empty;
  wire prxy_clash;
  wire do_push;
  wire do_pop;
  wire [31:0] push_c;
  wire [31:0] push_d;
  wire [31:0] bulk_c_use;
  wire [31:0] w0;
  wire [1:0] fent;
  wire set_err;
  wire set_ovfl;

  // a new request is one not yet answered
  assign req = cyc_i & stb_i & ~ack_ff & ~err_ff;
  assign wr = req & we_i;
  assign rd = req & ~we_i;
  assign q_full = (cnt_ff == QDEPTH[QAW:0]);
  assign q_empty = (cnt_ff == {(QAW+1){1'b0}});
  assign ack_o = ack_ff;
  assign err_o = err_ff;
  assign dat_o = dat_ff;
  assign swap_cd_o = ctrl_ff[`DQA_CTRL_SWAP];
  assign peer_info_buf_o = peer_info_ff;

  // address decode
  always @*
  begin
    hit_bulk_c = 1'b0;
    hit_bulk_d = 1'b0;
    hit_peri_d = 1'b0;
    hit_prxy_c = 1'b0;
    hit_prxy_d = 1'b0;
    hit_cnt = 1'b0;
    hit_size = 1'b0;
    hit_bytes = 1'b0;
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    hit_flow = 1'b0;
    flow_idx = adr_i[FW+1:2];
    if (adr_i == `DQA_OFS_BULK_C)
      hit_bulk_c = 1'b1;
    else if (adr_i == `DQA_OFS_BULK_D)
      hit_bulk_d = 1'b1;
    else if (adr_i == `DQA_OFS_PERI_D)
      hit_peri_d = 1'b1;
    else if (adr_i == `DQA_OFS_PRXY_C)
      hit_prxy_c = 1'b1;
    else if (adr_i == `DQA_OFS_PRXY_D)
      hit_prxy_d = 1'b1;
    else if (adr_i == `DQA_OFS_PEEK_CNT)
      hit_cnt = 1'b1;
    else if (adr_i == `DQA_OFS_PEEK_SIZE)
      hit_size = 1'b1;
    else if (adr_i == `DQA_OFS_PEEK_BYTES)
      hit_bytes = 1'b1;
    else if (adr_i == `DQA_OFS_CTRL)
      hit_ctrl = 1'b1;
    else if (adr_i == `DQA_OFS_STAT)
      hit_stat = 1'b1;
    else if (adr_i >= `DQA_OFS_FLOW0 && adr_i[1:0] == 2'h0 &&
             (adr_i - `DQA_OFS_FLOW0) < (FLOWS * 4))
      hit_flow = 1'b1;
  end

  // another master touching a half-built split access collides
  assign prxy_clash = req & (hit_prxy_c | hit_prxy_d) & prxy_busy_ff &
                      (mst_id_i != prxy_own_ff);

  // C stage pairs with D only from the master that wrote it
  assign bulk_c_use = (bulk_c_vld_ff && bulk_own_ff == mst_id_i) ?
                      bulk_c_ff : 32'h0000_0000;
  assign push_c = hit_prxy_d ? prxy_c_ff : bulk_c_use;
  assign push_d = dat_i;
  // writing D commits the C-plus-D pair as one push
  assign do_push = wr & ~prxy_clash & (hit_bulk_d | hit_prxy_d) &
                   ~q_full;
  // reading D pops, in the peripheral window or the split one
  assign do_pop = rd & ~prxy_clash & (hit_peri_d | hit_prxy_d) &
                  ~q_empty;
  assign set_err = prxy_clash;
  assign set_ovfl = wr & ~prxy_clash & (hit_bulk_d | hit_prxy_d) & q_full;

  // bus answer: one registered ack or err per request
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= req & ~prxy_clash;
      err_ff <= prxy_clash;
    end
  end

  // read data, captured with the answer
  always @(posedge clk_i)
  begin
    if (rst_i)
      dat_ff <= 32'h0000_0000;
    else if (rd)
    begin
      if (hit_peri_d | hit_prxy_d)
        dat_ff <= (q_empty | prxy_clash) ? 32'h0000_0000 :
                  qptr_ff[rd_ff];
      else if (hit_cnt)
        dat_ff <= {{(31-QAW){1'b0}}, cnt_ff};
      else if (hit_size)
        dat_ff <= q_empty ? 32'h0000_0000 : qsize_ff[rd_ff];
      else if (hit_bytes)
        dat_ff <= bytes_ff;
      else if (hit_ctrl)
        dat_ff <= ctrl_ff;
      else if (hit_stat)
        dat_ff <= {30'h0000_0000, ovfl_ff, prxy_err_ff};
      else if (hit_flow)
        dat_ff <= {30'h0000_0000, flow_ff[flow_idx]};
      else
        dat_ff <= 32'h0000_0000;
    end
    else
      dat_ff <= 32'h0000_0000;
  end

  // queue storage, pointers, count and byte total
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ff <= {QAW{1'b0}};
      rd_ff <= {QAW{1'b0}};
      cnt_ff <= {(QAW+1){1'b0}};
      bytes_ff <= 32'h0000_0000;
    end
    else if (do_push)
    begin
      qptr_ff[wr_ff] <= push_d;
      qsize_ff[wr_ff] <= push_c;
      wr_ff <= wr_ff + {{(QAW-1){1'b0}}, 1'b1};
      cnt_ff <= cnt_ff + {{QAW{1'b0}}, 1'b1};
      bytes_ff <= bytes_ff + {16'h0000, push_c[15:0]};
    end
    else if (do_pop)
    begin
      rd_ff <= rd_ff + {{(QAW-1){1'b0}}, 1'b1};
      cnt_ff <= cnt_ff - {{QAW{1'b0}}, 1'b1};
      bytes_ff <= bytes_ff - {16'h0000, qsize_ff[rd_ff][15:0]};
    end
  end

  // C staging for the bulk window: dropped once its master writes D, even when the queue is full
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bulk_c_ff <= 32'h0000_0000;
      bulk_c_vld_ff <= 1'b0;
      bulk_own_ff <= 4'h0;
    end
    else if (wr & hit_bulk_c)
    begin
      bulk_c_ff <= dqa_merge(32'h0000_0000, dat_i, sel_i);
      bulk_c_vld_ff <= 1'b1;
      bulk_own_ff <= mst_id_i;
    end
    else if (wr & hit_bulk_d & (bulk_own_ff == mst_id_i))
      bulk_c_vld_ff <= 1'b0;
  end

  // split window: C opens an access owned by one master, D closes it
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prxy_c_ff <= 32'h0000_0000;
      prxy_busy_ff <= 1'b0;
      prxy_own_ff <= 4'h0;
    end
    else if (req & ~prxy_clash)
    begin
      if (wr & hit_prxy_c)
      begin
        prxy_c_ff <= dqa_merge(32'h0000_0000, dat_i, sel_i);
        prxy_busy_ff <= 1'b1;
        prxy_own_ff <= mst_id_i;
      end
      else if (hit_prxy_d)
      begin
        prxy_c_ff <= 32'h0000_0000;
        prxy_busy_ff <= 1'b0;
      end
    end
  end

  // control, flow table and sticky status; a set beats a clear
  integer k;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_ff <= `DQA_CTRL_RST;
      prxy_err_ff <= 1'b0;
      ovfl_ff <= 1'b0;
      for (k = 0; k < FLOWS; k = k + 1)
        flow_ff[k] <= `DQA_FLOW_RST;
    end
    else
    begin
      if (wr & hit_ctrl & sel_i[0])
        ctrl_ff <= {31'h0000_0000, dat_i[`DQA_CTRL_SWAP]};
      if (wr & hit_flow & sel_i[0])
        flow_ff[flow_idx] <= dat_i[1:0];
      if (set_err)
        prxy_err_ff <= 1'b1;
      else if (wr & hit_stat & sel_i[0] & dat_i[`DQA_STAT_PRXY_ERR])
        prxy_err_ff <= 1'b0;
      if (set_ovfl)
        ovfl_ff <= 1'b1;
      else if (wr & hit_stat & sel_i[0] & dat_i[`DQA_STAT_OVFL])
        ovfl_ff <= 1'b0;
    end
  end

  // receive descriptor word 0 built from the flow entry
  assign fent = flow_ff[rx_flow_i];
  assign w0 = {1'b0,
               fent[`DQA_FLOW_TAG_EN] ? rx_tag_i : 8'h00,
               fent[`DQA_FLOW_INFO_LOC],
               rx_len_i};

  // stalls by the memory writer push back to the receive side
  dqa_buf2 #(
    .W(32)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(rx_valid_i),
    .in_ready_o(rx_ready_o),
    .in_data_i(w0),
    .out_valid_o(dsc_valid_o),
    .out_ready_i(dsc_ready_i),
    .out_data_o(dsc_word0_o)
  );

  // descriptors from a peer module: read where its protocol words sit
  always @(posedge clk_i)
  begin
    if (rst_i)
      peer_info_ff <= 1'b0;
    else if (peer_valid_i)
      peer_info_ff <= peer_word0_i[`DQA_W0_INFO_LOC];
  end

endmodule
`default_nettype wire

//--- dqa_map.vh
`ifndef DQA_MAP_VH
`define DQA_MAP_VH

// register byte offsets on the wishbone port
`define DQA_OFS_BULK_C 8'h00
`define DQA_OFS_BULK_D 8'h04
`define DQA_OFS_PERI_D 8'h08
`define DQA_OFS_PRXY_C 8'h0c
`define DQA_OFS_PRXY_D 8'h10
`define DQA_OFS_PEEK_CNT 8'h14
`define DQA_OFS_PEEK_SIZE 8'h18
`define DQA_OFS_PEEK_BYTES 8'h1c
`define DQA_OFS_CTRL 8'h20
`define DQA_OFS_STAT 8'h24
`define DQA_OFS_FLOW0 8'h40

// field positions
`define DQA_W0_INFO_LOC 22
`define DQA_W0_TAG_LO 23
`define DQA_W0_TAG_HI 30
`define DQA_FLOW_INFO_LOC 0
`define DQA_FLOW_TAG_EN 1
`define DQA_CTRL_SWAP 0
`define DQA_STAT_PRXY_ERR 0
`define DQA_STAT_OVFL 1

// reset values
`define DQA_CTRL_RST 32'h0000_0000
`define DQA_FLOW_RST 2'h0

// widest burst a core may issue, and its span in words
`define DQA_CORE_BURST_BYTES 8
`define DQA_CORE_BURST_WORDS (`DQA_CORE_BURST_BYTES / 4)

`endif

//--- dqa_buf2.v
`timescale 1ns/10ps
`default_nettype none

// two-entry buffer: a receiver stall loses no word
module dqa_buf2 #(
  parameter W = 32
) (
  input wire clk_i,            // system clock
  input wire rst_i,            // synchronous reset
  input wire in_valid_i,       // word offered
  output wire in_ready_o,      // room for a word
  input wire [W-1:0] in_data_i, // offered word
  output wire out_valid_o,     // word available
  input wire out_ready_i,      // receiver takes word
  output wire [W-1:0] out_data_o // head word
);

  reg [W-1:0] mem_ff [0:1];
  reg wp_ff;
  reg rp_ff;
  reg [1:0] cnt_ff;
  wire push;
  wire pop;

  // honest full and empty flags
  assign in_ready_o = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o = mem_ff[rp_ff];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // storage and pointers
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
      cnt_ff <= 2'h0;
      mem_ff[0] <= {W{1'b0}};
      mem_ff[1] <= {W{1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem_ff[wp_ff] <= in_data_i;
        wp_ff <= ~wp_ff;
      end
      if (pop)
        rp_ff <= ~rp_ff;
      if (push & ~pop)
        cnt_ff <= cnt_ff + 2'h1;
      else if (pop & ~push)
        cnt_ff <= cnt_ff - 2'h1;
    end
  end

endmodule
`default_nettype wire

//--- dqa_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks of bus answers, receive buffer and peer bit
module dqa_top_asserts (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic cyc_i, // cycle
  input wire logic stb_i, // strobe
  input wire logic we_i, // write
  input wire logic [7:0] adr_i, // address
  input wire logic [31:0] dat_i, // write data
  input wire logic [31:0] dat_o, // read data
  input wire logic ack_o, // ack
  input wire logic err_o, // error
  input wire logic rx_valid_i, // packet offered
  input wire logic rx_ready_o, // room
  input wire logic [21:0] rx_len_i, // length
  input wire logic dsc_valid_o, // word held
  input wire logic dsc_ready_i, // word taken
  input wire logic [31:0] dsc_word0_o, // word 0
  input wire logic peer_valid_i, // peer word
  input wire logic [31:0] peer_word0_i, // peer word 0
  input wire logic peer_info_buf_o, // peer bit
  input wire logic swap_cd_o // swap
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // request seen by the slave in this cycle
  sequence s_take;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  // answer pulse, then quiet
  sequence s_pulse;
    (ack_o || err_o) ##1 (!ack_o && !err_o);
  endsequence
  a_answer_next: assert property (s_take |=> s_pulse)
    else $error("request not answered in one cycle");
  a_ack_err_excl: assert property (!(ack_o && err_o))
    else $error("ack and error together");
  a_err_split: assert property (err_o |-> adr_i inside {8'h0c, 8'h10})
    else $error("error outside the split window");
  a_rd_quiet: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside an ack");
  a_swap_ctrl: assert property (ack_o && we_i && adr_i == 8'h20
    |=> swap_cd_o == $past(dat_i[0]))
    else $error("swap output not following control");
  a_peer_bit: assert property (peer_valid_i
    |=> peer_info_buf_o == $past(peer_word0_i[22]))
    else $error("peer location bit not taken");
  a_rx_head: assert property (rx_valid_i && rx_ready_o && !dsc_valid_o
    |=> dsc_valid_o && dsc_word0_o[21:0] == $past(rx_len_i))
    else $error("received length not at head");
  a_dsc_hold: assert property (dsc_valid_o && !dsc_ready_i
    |=> dsc_valid_o && $stable(dsc_word0_o))
    else $error("held descriptor word changed");
endmodule

bind dqa_top dqa_top_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .err_o(err_o), .rx_valid_i(rx_valid_i),
  .rx_ready_o(rx_ready_o), .rx_len_i(rx_len_i), .dsc_valid_o(dsc_valid_o),
  .dsc_ready_i(dsc_ready_i), .dsc_word0_o(dsc_word0_o),
  .peer_valid_i(peer_valid_i), .peer_word0_i(peer_word0_i),
  .peer_info_buf_o(peer_info_buf_o), .swap_cd_o(swap_cd_o)
);
`default_nettype wire

//--- dqa_wb_master.sv
`timescale 1ns/10ps
`default_nettype none
// bus master model: classic single cycles, one word each
module dqa_wb_master (
  input wire logic clk_i, // clock
  output logic cyc_o, // cycle
  output logic stb_o, // strobe
  output logic we_o, // write
  output logic [7:0] adr_o, // address
  output logic [3:0] sel_o, // byte enables
  output logic [31:0] dat_o, // write data
  output logic [3:0] id_o, // master id
  input wire logic [31:0] dat_i, // read data
  input wire logic ack_i, // ack
  input wire logic err_i // error
);
  // idle bus at time zero
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
    id_o = 4'h0;
  end
  // held until ack or error; released write, address and data lines show inverted values
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] id,
    output logic [31:0] q, output logic e);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hf; // one word per transfer, never a burst
    dat_o <= d;
    id_o <= id; // one master owns a whole queue word group
    do @(posedge clk_i);
    while (ack_i !== 1'b1 && err_i !== 1'b1);
    q = dat_i;
    e = err_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= ~w;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

//--- dqa_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module dqa_top_bench;
  logic clk_i, rst_i, rx_valid_i, dsc_ready_i, peer_valid_i;
  logic [1:0] rx_flow_i;
  logic [21:0] rx_len_i;
  logic [7:0] rx_tag_i;
  logic [31:0] peer_word0_i;
  wire cyc, stb, we, ack_o, err_o, rx_ready_o, dsc_valid_o;
  wire peer_info_buf_o, swap_cd_o;
  wire [7:0] adr;
  wire [3:0] sel, mid;
  wire [31:0] wdat, rdat, dsc_word0_o;
  int n_fail;
  int comparisons;

  dqa_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack_o), .err_o(err_o), .mst_id_i(mid), .rx_valid_i(rx_valid_i),
    .rx_ready_o(rx_ready_o), .rx_flow_i(rx_flow_i), .rx_len_i(rx_len_i),
    .rx_tag_i(rx_tag_i), .dsc_valid_o(dsc_valid_o),
    .dsc_ready_i(dsc_ready_i), .dsc_word0_o(dsc_word0_o),
    .peer_valid_i(peer_valid_i), .peer_word0_i(peer_word0_i),
    .peer_info_buf_o(peer_info_buf_o), .swap_cd_o(swap_cd_o));
  dqa_wb_master u_mst (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat), .id_o(mid), .dat_i(rdat),
    .ack_i(ack_o), .err_i(err_o));

  // 125 MHz clock
  always #4 clk_i = ~clk_i;

  task automatic final_report;
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // bus write; ee says whether an error answer is due
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] id, input logic ee);
    logic [31:0] q;
    logic e;
    u_mst.xfer(1'b1, a, d, id, q, e);
    chk("error answer", {31'h0, ee}, {31'h0, e});
  endtask
  // bus read against the expected word
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input logic [3:0] id);
    logic [31:0] q;
    logic e;
    u_mst.xfer(1'b0, a, 32'h0, id, q, e);
    chk("read data", x, q);
  endtask
  // offer one packet until taken
  task automatic rx_send(input logic [1:0] f, input logic [21:0] l,
    input logic [7:0] t);
    @(posedge clk_i);
    rx_valid_i <= 1'b1;
    rx_flow_i <= f;
    rx_len_i <= l;
    rx_tag_i <= t;
    do @(posedge clk_i);
    while (rx_ready_o !== 1'b1);
    rx_valid_i <= 1'b0;
    rx_len_i <= ~l;
    #1;
  endtask
  // check the head word, then take it
  task automatic take(input logic [31:0] x);
    chk("descriptor valid", 32'h1, {31'h0, dsc_valid_o});
    chk("descriptor word", x, dsc_word0_o);
    @(posedge clk_i);
    dsc_ready_i <= 1'b1;
    @(posedge clk_i);
    dsc_ready_i <= 1'b0;
    #1;
  endtask

  task automatic t_reset;
    rd(8'h14, 32'h0, 4'h1);
    rd(8'h20, 32'h0, 4'h1);
    rd(8'h40, 32'h0, 4'h1);
    chk("buffer room", 32'h1, {31'h0, rx_ready_o});
  endtask
  task automatic t_push_pop;
    wr(8'h00, 32'h40, 4'h2, 1'b0);
    wr(8'h04, 32'h1000, 4'h2, 1'b0);
    wr(8'h04, 32'h2000, 4'h3, 1'b0);
    rd(8'h14, 32'h2, 4'h2);
    rd(8'h18, 32'h40, 4'h2);
    rd(8'h1c, 32'h40, 4'h2);
    rd(8'h08, 32'h1000, 4'h2);
    rd(8'h14, 32'h1, 4'h2);
    rd(8'h08, 32'h2000, 4'h3);
    rd(8'h08, 32'h0, 4'h2);
    wr(8'h30, 32'h5, 4'h2, 1'b0);
    rd(8'h30, 32'h0, 4'h2);
  endtask
  task automatic t_split;
    wr(8'h0c, 32'h10, 4'h1, 1'b0);
    wr(8'h10, 32'h3000, 4'h2, 1'b1);
    rd(8'h24, 32'h1, 4'h1);
    wr(8'h24, 32'h1, 4'h1, 1'b0);
    rd(8'h24, 32'h0, 4'h1);
    wr(8'h10, 32'h3000, 4'h1, 1'b0);
    rd(8'h18, 32'h10, 4'h1);
    rd(8'h10, 32'h3000, 4'h1);
    rd(8'h14, 32'h0, 4'h1);
  endtask
  task automatic t_rx;
    wr(8'h40, 32'h3, 4'h2, 1'b0);
    wr(8'h44, 32'h2, 4'h2, 1'b0);
    rd(8'h40, 32'h3, 4'h2);
    rx_send(2'h0, 22'h123, 8'h5a);
    rx_send(2'h1, 22'h3ff, 8'ha5);
    chk("buffer room", 32'h0, {31'h0, rx_ready_o});
    take({1'b0, 8'h5a, 1'b1, 22'h123});
    take({1'b0, 8'ha5, 1'b0, 22'h3ff});
    rx_send(2'h2, 22'h7, 8'hff);
    take({10'h0, 22'h7});
    chk("descriptor valid", 32'h0, {31'h0, dsc_valid_o});
  endtask
  task automatic t_peer;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_i);
      peer_valid_i <= 1'b1;
      peer_word0_i <= {9'h0, i == 0, 22'h0};
      @(posedge clk_i);
      peer_valid_i <= 1'b0;
      peer_word0_i <= {9'h1ff, i != 0, 22'h3fffff};
      #1;
      chk("peer bit", {31'h0, i == 0}, {31'h0, peer_info_buf_o});
    end
  endtask
  task automatic t_ctrl;
    wr(8'h20, 32'h1, 4'h2, 1'b0);
    chk("swap", 32'h1, {31'h0, swap_cd_o});
    rd(8'h20, 32'h1, 4'h2);
    wr(8'h20, 32'h0, 4'h2, 1'b0);
  endtask

  // fill the queue to its depth, overflow once, then drain it
  task automatic t_full;
    for (int i = 0; i < 16; i++)
      wr(8'h04, 32'h100 + i, 4'h4, 1'b0);
    rd(8'h14, 32'h10, 4'h4);
    wr(8'h04, 32'h999, 4'h4, 1'b0);
    rd(8'h24, 32'h2, 4'h4);
    rd(8'h14, 32'h10, 4'h4);
    for (int i = 0; i < 16; i++)
      rd(8'h08, 32'h100 + i, 4'h4);
    rd(8'h08, 32'h0, 4'h4);
    wr(8'h24, 32'h2, 4'h4, 1'b0);
    rd(8'h24, 32'h0, 4'h4);
  endtask
  // receive path idle, then a reset in mid-run clears count, flow entry, swap and buffer
  task automatic t_mid_reset;
    wr(8'h00, 32'h8, 4'h2, 1'b0);
    wr(8'h04, 32'h4000, 4'h2, 1'b0);
    wr(8'h20, 32'h1, 4'h2, 1'b0);
    chk("descriptor valid", 32'h0, {31'h0, dsc_valid_o});
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h14, 32'h0, 4'h2);
    rd(8'h40, 32'h0, 4'h2);
    chk("swap", 32'h0, {31'h0, swap_cd_o});
    chk("buffer room", 32'h1, {31'h0, rx_ready_o});
  endtask

  // stop a hang
  initial
  begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    final_report;
  end
  // main sequence
  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    rx_valid_i = 1'b0;
    rx_flow_i = 2'h0;
    rx_len_i = 22'h0;
    rx_tag_i = 8'h00;
    dsc_ready_i = 1'b0;
    peer_valid_i = 1'b0;
    peer_word0_i = 32'h0;
    n_fail = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_push_pop;
    t_full;
    t_split;
    t_rx;
    t_peer;
    t_ctrl;
    t_mid_reset;
    final_report;
  end
endmodule
`default_nettype wire
